// ==== vrr_pkg.sv ====
// Constants and types for the serial-bus register file
package vrr_pkg;
    localparam logic [7:0] IDX_PRIMARY_STATUS = 8'h10;
    localparam logic [7:0] IDX_BUS_ERROR_STATUS = 8'h11;
    localparam logic [7:0] IDX_ERROR_SHADOW = 8'h1c;
    localparam logic [7:0] IDX_TEMP_MAX = 8'h22;
    localparam logic [7:0] IDX_UNSUP_LO = 8'h27;
    localparam logic [7:0] IDX_UNSUP_HI = 8'h2f;
    localparam logic [7:0] IDX_CEILING = 8'h30;
    localparam logic [7:0] IDX_SETPOINT = 8'h31;
    localparam logic [7:0] IDX_POWER_STATE = 8'h32;
    localparam logic [7:0] IDX_MARGIN = 8'h33;
    localparam logic [7:0] IDX_MULTI_CFG = 8'h34;
    localparam logic [7:0] IDX_SCRATCH = 8'h35;
    localparam logic [7:0] IDX_UNUSED_LO = 8'h36;
    localparam logic [7:0] IDX_UNUSED_HI = 8'h6f;
    localparam logic [7:0] RST_CEILING = 8'hfb;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] TEMP_MAX_VALUE = 8'h64;
    localparam int BIT_SETTLED = 0;
    localparam int BIT_THERM = 1;
    localparam int BIT_OVERCUR = 2;
    localparam int BIT_ERR_CHANGE = 7;
    localparam int BIT_PARITY = 0;
    localparam int BIT_FRAME = 1;
    // Zone bit that marks 97 percent of the maximum temperature
    localparam int ZONE_BIT_97 = 6;
    // Bus commands
    typedef enum logic [2:0]
    {
        VRR_CMD_NONE = 3'h0,
        VRR_CMD_SET_VOLTAGE = 3'h1,
        VRR_CMD_GET_REGISTER = 3'h2,
        VRR_CMD_SET_INDEX = 3'h3,
        VRR_CMD_SET_INDEXED_DATA = 3'h4
    } vrr_cmd_t;
    // Acknowledge codes
    typedef enum logic [1:0]
    {
        VRR_ACK_NONE = 2'h0,
        VRR_ACK_OK = 2'h1,
        VRR_ACK_NOT_SUPPORTED = 2'h2
    } vrr_ack_t;
endpackage

// ==== vrr_register_file.sv ====
// Serial-bus register file of a dual-output regulator controller
`timescale 1ns/1ps
module vrr_register_file
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire vrr_pkg::vrr_cmd_t cmd,
    input wire logic [7:0] cmd_index,
    input wire logic [7:0] cmd_data,
    input wire logic parity_error,
    input wire logic frame_error,
    input wire logic output_in_window,
    input wire logic [7:0] temperature_zone,
    input wire logic overcurrent_flag,
    input wire logic pwm_state_we,
    input wire logic [7:0] pwm_state_data,
    output logic [1:0] ack_reg,
    output logic [7:0] read_data_reg,
    output logic alert_n_reg,
    output logic [7:0] target_code_reg,
    output logic [7:0] power_state_reg,
    output logic [7:0] multi_regulator_config_reg
);
    import vrr_pkg::*;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] ceiling_reg;
    logic [7:0] setpoint_reg;
    logic [7:0] margin_reg;
    logic [7:0] scratch_reg;
    logic [7:0] err_reg;
    logic [7:0] shadow_reg;
    logic settled_reg;
    logic overcur_latch_reg;
    logic err_change_reg;
    logic slewing_reg;
    logic [7:0] status_live;
    logic [7:0] status_prev_reg;
    logic write_any;
    logic [7:0] write_index;
    logic write_hit;
    logic unsupported;
    logic read_status;
    logic read_err;
    logic [7:0] read_value;
    logic sv_over;

    assign read_status = (cmd == VRR_CMD_GET_REGISTER) && (cmd_index == IDX_PRIMARY_STATUS);
    assign read_err = (cmd == VRR_CMD_GET_REGISTER) && (cmd_index == IDX_BUS_ERROR_STATUS);
    // Indexed data goes to the scratch pointer, not the command index
    assign write_any = (cmd == VRR_CMD_SET_INDEXED_DATA);
    assign write_index = scratch_reg;
    assign sv_over = (cmd == VRR_CMD_SET_VOLTAGE) && (cmd_data > ceiling_reg);
    assign write_hit = write_any && (write_index >= IDX_CEILING) && (write_index <= IDX_SCRATCH);

    // ----------------------------------------
    // Status assembly
    // ----------------------------------------
    always_comb
    begin
        status_live = 8'h00;
        status_live[BIT_SETTLED] = settled_reg;
        status_live[BIT_THERM] = temperature_zone[ZONE_BIT_97];
        status_live[BIT_OVERCUR] = overcur_latch_reg;
        status_live[BIT_ERR_CHANGE] = err_change_reg;
    end

    always_comb
    begin
        unsupported = 1'b0;
        read_value = 8'h00;
        case (cmd_index)
            IDX_PRIMARY_STATUS: read_value = status_live;
            IDX_BUS_ERROR_STATUS: read_value = err_reg;
            IDX_ERROR_SHADOW: read_value = shadow_reg;
            IDX_TEMP_MAX: read_value = TEMP_MAX_VALUE;
            IDX_CEILING: read_value = ceiling_reg;
            IDX_SETPOINT: read_value = setpoint_reg;
            IDX_POWER_STATE: read_value = power_state_reg;
            IDX_MARGIN: read_value = margin_reg;
            IDX_MULTI_CFG: read_value = multi_regulator_config_reg;
            IDX_SCRATCH: read_value = scratch_reg;
            default:
            begin
                // Unlisted indexes outside 0x27-0x2f and 0x36-0x6f belong to blocks outside this file; those two ranges are refused
                if ((cmd_index >= IDX_UNSUP_LO && cmd_index <= IDX_UNSUP_HI) ||
                    (cmd_index >= IDX_UNUSED_LO && cmd_index <= IDX_UNUSED_HI))
                begin
                    unsupported = 1'b1;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Master-writable registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ceiling_reg <= RST_CEILING;
            setpoint_reg <= RST_ZERO;
            margin_reg <= RST_ZERO;
            multi_regulator_config_reg <= RST_ZERO;
            scratch_reg <= RST_ZERO;
        end
        else if (clk_en)
        begin
            if (cmd == VRR_CMD_SET_INDEX)
                scratch_reg <= cmd_data;
            if (cmd == VRR_CMD_SET_VOLTAGE && !sv_over)
                setpoint_reg <= cmd_data;
            if (write_hit)
            begin
                case (write_index)
                    IDX_CEILING: ceiling_reg <= cmd_data;
                    IDX_SETPOINT: setpoint_reg <= cmd_data;
                    IDX_MARGIN: margin_reg <= cmd_data;
                    IDX_MULTI_CFG: multi_regulator_config_reg <= cmd_data;
                    IDX_SCRATCH: scratch_reg <= cmd_data;
                    default: ;
                endcase
            end
        end
    end

    // Regulator logic wins over a same-cycle master write
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_state_reg <= RST_ZERO;
        else if (clk_en)
        begin
            if (pwm_state_we)
                power_state_reg <= pwm_state_data;
            else if (write_hit && write_index == IDX_POWER_STATE)
                power_state_reg <= cmd_data;
        end
    end

    // Offset wraps in 8 bits; no saturation applied
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            target_code_reg <= RST_ZERO;
        else if (clk_en)
            target_code_reg <= 8'(setpoint_reg + margin_reg);
    end

    // ----------------------------------------
    // Settling and overcurrent
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slewing_reg <= 1'b0;
            settled_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cmd == VRR_CMD_SET_VOLTAGE && !sv_over)
            begin
                slewing_reg <= 1'b1;
                settled_reg <= 1'b0;
            end
            else if (slewing_reg && output_in_window)
            begin
                slewing_reg <= 1'b0;
                settled_reg <= 1'b1;
            end
        end
    end

    // Latch sets on the event; a status read reloads it from the live flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            overcur_latch_reg <= 1'b0;
        else if (clk_en)
        begin
            if (overcurrent_flag)
                overcur_latch_reg <= 1'b1;
            else if (read_status)
                overcur_latch_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Error status and shadow
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_reg <= RST_ZERO;
            shadow_reg <= RST_ZERO;
            err_change_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (read_err)
                shadow_reg <= err_reg;
            // New errors win over the clear of a read in the same cycle
            err_reg <= 8'h00;
            err_reg[BIT_PARITY] <= parity_error | (err_reg[BIT_PARITY] & ~read_err);
            err_reg[BIT_FRAME] <= frame_error | (err_reg[BIT_FRAME] & ~read_err);
            if (parity_error || frame_error)
                err_change_reg <= 1'b1;
            else if (read_err)
                err_change_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Answer and alert
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= VRR_ACK_NONE;
            read_data_reg <= RST_ZERO;
        end
        else if (clk_en)
        begin
            ack_reg <= VRR_ACK_NONE;
            if (sv_over)
                ack_reg <= VRR_ACK_NOT_SUPPORTED;
            else if (cmd == VRR_CMD_GET_REGISTER)
            begin
                ack_reg <= unsupported ? VRR_ACK_NOT_SUPPORTED : VRR_ACK_OK;
                read_data_reg <= read_value;
            end
            else if (write_any)
                ack_reg <= write_hit ? VRR_ACK_OK : VRR_ACK_NOT_SUPPORTED;
            else if (cmd != VRR_CMD_NONE)
                ack_reg <= VRR_ACK_OK;
        end
    end

    // Alert held low until the master reads primary status
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_prev_reg <= RST_ZERO;
            alert_n_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            status_prev_reg <= status_live;
            if (status_live != status_prev_reg)
                alert_n_reg <= 1'b0;
            else if (read_status)
                alert_n_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence err_read_s;
        clk_en && read_err && !parity_error && !frame_error;
    endsequence

    ceiling_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && sv_over |=> ack_reg == VRR_ACK_NOT_SUPPORTED)
        else $error("setpoint above ceiling not refused");
    setpoint_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && sv_over |=> setpoint_reg == $past(setpoint_reg))
        else $error("refused setpoint was stored");
    pwm_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && pwm_state_we |=> power_state_reg == $past(pwm_state_data))
        else $error("power state not taken from regulator");
    target_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> target_code_reg == 8'($past(setpoint_reg) + $past(margin_reg)))
        else $error("target code not setpoint plus offset");
    index_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd == VRR_CMD_SET_INDEX |=> scratch_reg == $past(cmd_data))
        else $error("index payload not stored");
    unused_index_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd == VRR_CMD_GET_REGISTER && cmd_index == 8'h40
        |=> ack_reg == VRR_ACK_NOT_SUPPORTED)
        else $error("unused index acknowledged");
    status_alert_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && status_live != status_prev_reg |=> !alert_n_reg)
        else $error("alert missing on status change");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        status_live[6:3] == 4'h0 && err_reg[7:2] == 6'h00)
        else $error("reserved status bits set");
    shadow_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        err_read_s |=> shadow_reg == $past(err_reg) && err_reg == 8'h00)
        else $error("error status not copied and cleared");
    overcur_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && overcurrent_flag ##1 (clk_en && !read_status)[*2]
        |=> overcur_latch_reg)
        else $error("overcurrent latch lost");
endmodule // vrr_register_file

// ==== vrr_bus_master.sv ====
// Behavioural model of the serial bus master facing the register file
`timescale 1ns/1ps
module vrr_bus_master
(
    input wire logic ref_clk,
    output vrr_pkg::vrr_cmd_t cmd,
    output logic [7:0] cmd_index,
    output logic [7:0] cmd_data,
    input wire logic [1:0] ack_reg,
    input wire logic [7:0] read_data_reg
);
    import vrr_pkg::*;
    initial
    begin
        cmd = VRR_CMD_NONE;
        cmd_index = 8'h00;
        cmd_data = 8'h00;
    end
    // One-cycle command pulse; answer taken once the taking edge has landed
    task automatic issue(input vrr_cmd_t c, input logic [7:0] idx, input logic [7:0] dat,
        output logic [1:0] ack, output logic [7:0] rd);
        @(posedge ref_clk);
        cmd <= c;
        cmd_index <= idx;
        cmd_data <= dat;
        @(posedge ref_clk);
        cmd <= VRR_CMD_NONE;
        // Released fields flip so a stale value is never mistaken for a live one
        cmd_index <= ~idx;
        cmd_data <= ~dat;
        #1;
        ack = ack_reg;
        rd = read_data_reg;
    endtask
    // Indexed write; also the boot-time ceiling programming step
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] dat,
        output logic [1:0] ack);
        logic [1:0] a0;
        logic [7:0] rd;
        issue(VRR_CMD_SET_INDEX, 8'h00, idx, a0, rd);
        issue(VRR_CMD_SET_INDEXED_DATA, 8'h00, dat, ack, rd);
    endtask
endmodule // vrr_bus_master

// ==== tb.sv ====
// Self-checking testbench for the serial-bus register file
`timescale 1ns/1ps
module tb;
    import vrr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic parity_error = 1'b0;
    logic frame_error = 1'b0;
    logic output_in_window = 1'b0;
    logic [7:0] temperature_zone = 8'h00;
    logic overcurrent_flag = 1'b0;
    logic pwm_state_we = 1'b0;
    logic [7:0] pwm_state_data = 8'h00;
    vrr_cmd_t cmd;
    logic [7:0] cmd_index;
    logic [7:0] cmd_data;
    logic [1:0] ack_reg;
    logic [7:0] read_data_reg;
    logic alert_n_reg;
    logic [7:0] target_code_reg;
    logic [7:0] power_state_reg;
    logic [7:0] multi_regulator_config_reg;
    int err_total = 0;
    int comparisons = 0;
    logic [1:0] ak;
    logic [7:0] rd;
    logic [7:0] ceil;
    logic [7:0] sp;
    logic [7:0] off;
    logic [7:0] v;
    always #5 ref_clk = ~ref_clk;
    vrr_register_file DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd(cmd),
        .cmd_index(cmd_index), .cmd_data(cmd_data), .parity_error(parity_error),
        .frame_error(frame_error), .output_in_window(output_in_window),
        .temperature_zone(temperature_zone), .overcurrent_flag(overcurrent_flag),
        .pwm_state_we(pwm_state_we), .pwm_state_data(pwm_state_data), .ack_reg(ack_reg),
        .read_data_reg(read_data_reg), .alert_n_reg(alert_n_reg),
        .target_code_reg(target_code_reg), .power_state_reg(power_state_reg),
        .multi_regulator_config_reg(multi_regulator_config_reg));
    vrr_bus_master u_master (.ref_clk(ref_clk), .cmd(cmd), .cmd_index(cmd_index),
        .cmd_data(cmd_data), .ack_reg(ack_reg), .read_data_reg(read_data_reg));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic read_chk(input logic [7:0] idx, input logic [1:0] ea, input logic [7:0] ed);
        u_master.issue(VRR_CMD_GET_REGISTER, idx, 8'h00, ak, rd);
        check("ack code", {6'h00, ak}, {6'h00, ea});
        check("read data", rd, ed);
    endtask
    function automatic logic [7:0] status_exp(input logic s, input logic t, input logic o,
        input logic e);
        return {e, 4'h0, o, t, s};
    endfunction
    // Event pulse: 0 overcurrent, 1 parity, other frame
    task automatic pulse_wait(input int which);
        @(posedge ref_clk);
        case (which)
            0: overcurrent_flag <= 1'b1;
            1: parity_error <= 1'b1;
            default: frame_error <= 1'b1;
        endcase
        @(posedge ref_clk);
        overcurrent_flag <= 1'b0;
        parity_error <= 1'b0;
        frame_error <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Watchdog, sized well above the expected run
    // ----------------------------------------
    initial
    begin
        repeat (6000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h23e967d0));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        read_chk(IDX_CEILING, VRR_ACK_OK, RST_CEILING);
        read_chk(IDX_SETPOINT, VRR_ACK_OK, 8'h00);
        read_chk(IDX_POWER_STATE, VRR_ACK_OK, 8'h00);
        read_chk(IDX_MARGIN, VRR_ACK_OK, 8'h00);
        read_chk(IDX_MULTI_CFG, VRR_ACK_OK, 8'h00);
        read_chk(IDX_SCRATCH, VRR_ACK_OK, 8'h00);
        read_chk(IDX_ERROR_SHADOW, VRR_ACK_OK, 8'h00);
        read_chk(IDX_TEMP_MAX, VRR_ACK_OK, 8'h64);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, 8'h00);
        // Ceiling first, then setpoints against it; boundary codes on both sides
        ceil = 8'h80 + 8'($urandom_range(0, 126));
        u_master.write_reg(IDX_CEILING, ceil, ak);
        check("ceiling ack", {6'h00, ak}, 8'h01);
        u_master.issue(VRR_CMD_SET_VOLTAGE, 8'h00, ceil + 8'h01, ak, rd);
        check("over ceiling ack", {6'h00, ak}, 8'h02);
        read_chk(IDX_SETPOINT, VRR_ACK_OK, 8'h00);
        u_master.issue(VRR_CMD_SET_VOLTAGE, 8'h00, ceil, ak, rd);
        check("at ceiling ack", {6'h00, ak}, 8'h01);
        sp = 8'($urandom_range(0, 32'(ceil)));
        u_master.issue(VRR_CMD_SET_VOLTAGE, 8'h00, sp, ak, rd);
        read_chk(IDX_SETPOINT, VRR_ACK_OK, sp);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(0, 0, 0, 0));
        @(posedge ref_clk);
        output_in_window <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("alert low", {7'h00, alert_n_reg}, 8'h00);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 0, 0, 0));
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 0, 0, 0));
        check("alert released", {7'h00, alert_n_reg}, 8'h01);
        // Offsets, one negative corner among random ones
        for (int i = 0; i < 6; i++)
        begin
            off = (i == 0) ? 8'hff : 8'($urandom);
            u_master.write_reg(IDX_MARGIN, off, ak);
            @(posedge ref_clk);
            #1;
            check("target code", target_code_reg, sp + off);
        end
        v = 8'($urandom);
        u_master.write_reg(IDX_MULTI_CFG, v, ak);
        check("config port", multi_regulator_config_reg, v);
        read_chk(IDX_MULTI_CFG, VRR_ACK_OK, v);
        read_chk(IDX_SCRATCH, VRR_ACK_OK, IDX_MULTI_CFG);
        u_master.write_reg(IDX_POWER_STATE, 8'h02, ak);
        check("power port", power_state_reg, 8'h02);
        @(posedge ref_clk);
        pwm_state_we <= 1'b1;
        pwm_state_data <= 8'h03;
        @(posedge ref_clk);
        pwm_state_we <= 1'b0;
        read_chk(IDX_POWER_STATE, VRR_ACK_OK, 8'h03);
        // Frozen clock enable must swallow a regulator write
        @(posedge ref_clk);
        clk_en <= 1'b0;
        pwm_state_we <= 1'b1;
        pwm_state_data <= 8'h05;
        @(posedge ref_clk);
        pwm_state_we <= 1'b0;
        clk_en <= 1'b1;
        read_chk(IDX_POWER_STATE, VRR_ACK_OK, 8'h03);
        for (int i = 8'h27; i <= 8'h6f; i++)
            if (i < 8'h30 || i > 8'h35)
                read_chk(8'(i), VRR_ACK_NOT_SUPPORTED, 8'h00);
        u_master.write_reg(IDX_UNUSED_LO, 8'h5a, ak);
        check("unused write ack", {6'h00, ak}, 8'h02);
        // Thermal, latched overcurrent, then bus errors
        @(posedge ref_clk);
        temperature_zone <= 8'h7f;
        repeat (3) @(posedge ref_clk);
        #1;
        check("thermal alert", {7'h00, alert_n_reg}, 8'h00);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 1, 0, 0));
        pulse_wait(0);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 1, 1, 0));
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 1, 0, 0));
        pulse_wait(1);
        pulse_wait(2);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 1, 0, 1));
        read_chk(IDX_BUS_ERROR_STATUS, VRR_ACK_OK, 8'h03);
        read_chk(IDX_ERROR_SHADOW, VRR_ACK_OK, 8'h03);
        read_chk(IDX_PRIMARY_STATUS, VRR_ACK_OK, status_exp(1, 1, 0, 0));
        pulse_wait(1);
        read_chk(IDX_ERROR_SHADOW, VRR_ACK_OK, 8'h03);
        read_chk(IDX_BUS_ERROR_STATUS, VRR_ACK_OK, 8'h01);
        read_chk(IDX_ERROR_SHADOW, VRR_ACK_OK, 8'h01);
        read_chk(IDX_BUS_ERROR_STATUS, VRR_ACK_OK, 8'h00);
        // Indexed write into the scratch pointer itself
        u_master.write_reg(IDX_SCRATCH, IDX_CEILING, ak);
        check("scratch write ack", {6'h00, ak}, 8'h01);
        read_chk(IDX_SCRATCH, VRR_ACK_OK, IDX_CEILING);
        wrap_up();
    end
endmodule // tb
